// ==== indirect_register_access_tb.sv ====
// self-checking testbench for the indirect register bridge
`timescale 1ns/1ps
module indirect_register_access_tb;
    import ira_pkg::*;
    logic clk, resetn, irq_enable, irq_clear, eval_valid, data_wr, addr_wr;
    logic [15:0] wdata, bridge_data_reg, rd_val;
    logic [7:0] waddr, bridge_address_reg;
    logic bridge_pending_flag, transfer_complete_irq;
    ira_eval_t eval, ev;
    ira_result_t result;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    int n, t1, t2;
    logic [15:0] th [13] = '{16'h1000, 16'h2000, 16'h3000, 16'h7ff0, 16'h2000, 16'h07f0,
        16'h07f0, 16'h07f0, 16'h0111, 16'h0222, 16'h0333, 16'h0400, 16'h0555};
    ira_top dut (.clk(clk), .resetn(resetn), .data_wr(data_wr), .wdata(wdata),
        .addr_wr(addr_wr), .waddr(waddr), .irq_enable(irq_enable), .irq_clear(irq_clear),
        .eval_valid(eval_valid), .eval(eval), .bridge_data_reg(bridge_data_reg),
        .bridge_address_reg(bridge_address_reg), .bridge_pending_flag(bridge_pending_flag),
        .transfer_complete_irq(transfer_complete_irq), .result(result));
    ira_host host (.clk(clk), .bridge_pending_flag(bridge_pending_flag),
        .bridge_data_reg(bridge_data_reg), .data_wr(data_wr), .wdata(wdata),
        .addr_wr(addr_wr), .waddr(waddr));
    // ------------------------------------------------------------
    // clock, cycle count, watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // about forty transfers of at most 630 cycles each
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        $display("[FAIL] watchdog expected finish seen hang");
        test_done();
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic run_eval(input ira_eval_t e);
        @(negedge clk);
        eval = e;
        eval_valid = 1'b1;
        @(negedge clk);
        eval_valid = 1'b0;
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        irq_enable = 1'b0;
        irq_clear = 1'b0;
        eval_valid = 1'b0;
        eval = '0;
        repeat (20) @(negedge clk);
        chk("pending in reset", 32'(bridge_pending_flag), 32'h0);
        chk("irq in reset", 32'(transfer_complete_irq), 32'h0);
        resetn = 1'b1;
        for (int i = 0; i < 13; i++) host.wr(8'(i), th[i]);
        for (int i = 0; i < 13; i++) begin
            host.rd(8'(i), rd_val);
            chk("read back", 32'(rd_val), 32'(th[i]));
        end
        chk("irq masked", 32'(transfer_complete_irq), 32'h0);
        host.wr(8'h0d, 16'h1234);
        host.rd(8'h0d, rd_val);
        chk("beyond last word", 32'(rd_val), 32'h0);
        $display("test store and read back done");
        host.issue(8'h07);
        chk("pending raised", 32'(bridge_pending_flag), 32'h1);
        n = 0;
        while (bridge_pending_flag === 1'b1 && n < 700) begin
            @(negedge clk);
            n++;
        end
        chk("pending span", 32'(n <= TICK_CYCLES + 2), 32'h1);
        chk("read data", 32'(bridge_data_reg), 32'(th[7]));
        host.wr(8'h08, 16'h0abc);
        t1 = cyc;
        host.wr(8'h09, 16'h0def);
        t2 = cyc;
        chk("tick spacing", 32'((t2 - t1) % TICK_CYCLES), 32'h0);
        host.rd(8'h08, rd_val);
        chk("word 8", 32'(rd_val), 32'h0abc);
        host.rd(8'h09, rd_val);
        chk("read not write", 32'(rd_val), 32'h0def);
        chk("address held", 32'(bridge_address_reg), 32'h09);
        host.wr_both(8'h0a, 16'h0aaa);
        host.rd(8'h0a, rd_val);
        chk("same cycle write", 32'(rd_val), 32'h0aaa);
        $display("test pending and tick done");
        irq_enable = 1'b1;
        host.wr(8'h0c, 16'h5a5a);
        chk("irq set", 32'(transfer_complete_irq), 32'h1);
        @(negedge clk);
        irq_clear = 1'b1;
        @(negedge clk);
        irq_clear = 1'b0;
        chk("irq cleared", 32'(transfer_complete_irq), 32'h0);
        $display("test interrupt done");
        // equal values sit exactly on the low_ratio[1], forward twist and minimum power boundaries; negatives catch unsigned compares
        ev = '0;
        ev.low_ratio[0] = 16'h1001;
        ev.low_ratio[1] = 16'h2000;
        ev.low_ratio[2] = 16'hf000;
        ev.low_ratio[3] = 16'h7ff1;
        ev.high_ratio[0] = 16'h2001;
        ev.high_ratio[1] = 16'h1fff;
        ev.high_ratio[2] = 16'h8000;
        ev.high_ratio[3] = 16'h7fff;
        ev.fwd_ratio = 16'h07f0;
        ev.rev_ratio = 16'h07f1;
        ev.low_peak_ratio = 16'h07f1;
        ev.total_power = 16'h0400;
        run_eval(ev);
        @(negedge clk);
        chk("eval result", 32'(result), 32'({1'b1, 4'b1001, 4'b1001, 3'b101}));
        ev.total_power = 16'h03ff;
        ev.low_ratio[3] = PASS_UNITY;
        run_eval(ev);
        chk("low power valid", 32'(result.valid), 32'h0);
        chk("unity ratio", 32'(result.low_detect), 32'h1);
        $display("test evaluation done");
        test_done();
    end
endmodule

// ==== ira_host.sv ====
// host controller model driving the bridge's data and address loads
`timescale 1ns/1ps
module ira_host (
    input wire logic clk,
    input wire logic bridge_pending_flag,
    input wire logic [ira_pkg::DATA_W-1:0] bridge_data_reg,
    output logic data_wr,
    output logic [ira_pkg::DATA_W-1:0] wdata,
    output logic addr_wr,
    output logic [ira_pkg::ADDR_W-1:0] waddr
);
    import ira_pkg::*;
    // ------------------------------------------------------------
    // idle bus
    // ------------------------------------------------------------
    initial begin
        data_wr = 1'b0;
        addr_wr = 1'b0;
        wdata = 16'h0000;
        waddr = 8'h00;
    end
    // ------------------------------------------------------------
    // request tasks, all driven at the falling edge
    // ------------------------------------------------------------
    // bounded so a stuck flag ends in the watchdog, not here
    task automatic wait_idle();
        int n;
        n = 0;
        while (bridge_pending_flag !== 1'b0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic issue(input logic [7:0] a);
        @(negedge clk);
        addr_wr = 1'b1;
        waddr = a;
        @(negedge clk);
        addr_wr = 1'b0;
        // released lines show no stale value
        waddr = ~waddr;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        wait_idle();
        @(negedge clk);
        data_wr = 1'b1;
        wdata = d;
        @(negedge clk);
        data_wr = 1'b0;
        wdata = ~wdata;
        addr_wr = 1'b1;
        waddr = a;
        @(negedge clk);
        addr_wr = 1'b0;
        waddr = ~waddr;
        wait_idle();
    endtask
    // data and address loaded in one cycle still count as a write
    task automatic wr_both(input logic [7:0] a, input logic [15:0] d);
        wait_idle();
        @(negedge clk);
        data_wr = 1'b1;
        wdata = d;
        addr_wr = 1'b1;
        waddr = a;
        @(negedge clk);
        data_wr = 1'b0;
        wdata = ~wdata;
        addr_wr = 1'b0;
        waddr = ~waddr;
        wait_idle();
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        wait_idle();
        issue(a);
        wait_idle();
        d = bridge_data_reg;
    endtask
endmodule

// ==== ira_pkg.sv ====
// constants, types and records shared by the indirect register bridge
package ira_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_HZ = 16_000;
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
    localparam logic [9:0] TICK_LAST = 10'(TICK_CYCLES - 1);
    localparam logic [9:0] TICK_CNT_RESET = 10'h000;
    // ------------------------------------------------------------
    // widths and indirect addresses
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] NUM_WORDS = 8'h0d;
    localparam logic [7:0] ADDR_LOW_TONE0_PASS = 8'h00;
    localparam logic [7:0] ADDR_HIGH_GROUP_PASS = 8'h04;
    localparam logic [7:0] ADDR_FORWARD_TWIST = 8'h05;
    localparam logic [7:0] ADDR_REVERSE_TWIST = 8'h06;
    localparam logic [7:0] ADDR_LOW_PEAK_RATIO = 8'h07;
    localparam logic [7:0] ADDR_HIGH_PEAK_RATIO = 8'h08;
    localparam logic [7:0] ADDR_LOW_HARMONIC = 8'h09;
    localparam logic [7:0] ADDR_HIGH_HARMONIC = 8'h0a;
    localparam logic [7:0] ADDR_DTMF_MIN_POWER = 8'h0b;
    localparam logic [7:0] ADDR_DTMF_AGC_LIMIT = 8'h0c;
    // ------------------------------------------------------------
    // reset values and ratio scaling
    // ------------------------------------------------------------
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [15:0] PASS_UNITY = 16'h7ff0;
    localparam logic [15:0] TWIST_UNITY = 16'h07f0;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        IRA_IDLE = 2'b00,
        IRA_RD = 2'b01,
        IRA_WR = 2'b10
    } ira_req_t;
    typedef struct packed {
        logic [3:0][15:0] low_ratio;
        logic [3:0][15:0] high_ratio;
        logic [15:0] fwd_ratio;
        logic [15:0] rev_ratio;
        logic [15:0] low_peak_ratio;
        logic [15:0] total_power;
    } ira_eval_t;
    typedef struct packed {
        logic valid;
        logic [3:0] low_detect;
        logic [3:0] high_detect;
        logic fwd_twist_ok;
        logic rev_twist_ok;
        logic low_peak_ok;
    } ira_result_t;
    localparam ira_result_t RESULT_RESET = '0;
endpackage

// ==== ira_top.sv ====
// indirect register bridge with dtmf threshold store and compare
`timescale 1ns/1ps
module ira_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic data_wr,
    input wire logic [ira_pkg::DATA_W-1:0] wdata,
    input wire logic addr_wr,
    input wire logic [ira_pkg::ADDR_W-1:0] waddr,
    input wire logic irq_enable,
    input wire logic irq_clear,
    input wire logic eval_valid,
    input wire ira_pkg::ira_eval_t eval,
    output logic [ira_pkg::DATA_W-1:0] bridge_data_reg,
    output logic [ira_pkg::ADDR_W-1:0] bridge_address_reg,
    output logic bridge_pending_flag,
    output logic transfer_complete_irq,
    output ira_pkg::ira_result_t result
);
    import ira_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic ira_in_range(input logic [7:0] a);
        return a < NUM_WORDS;
    endfunction

    function automatic logic ira_gt(input logic [15:0] a, input logic [15:0] b);
        return $signed(a) > $signed(b);
    endfunction

    // ------------------------------------------------------------
    // update tick divider
    // ------------------------------------------------------------
    logic [9:0] cnt_reg;
    logic [9:0] cnt_next;
    logic tick_reg;
    logic tick_next;

    always_comb begin
        tick_next = 1'b0;
        cnt_next = cnt_reg + 10'h001;
        if (cnt_reg == TICK_LAST) begin
            cnt_next = TICK_CNT_RESET;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= TICK_CNT_RESET;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    // ------------------------------------------------------------
    // indirect storage
    // ------------------------------------------------------------
    // no reset on purpose: contents are undefined until programmed
    logic [15:0] mem [0:12];
    logic mem_we;
    logic [15:0] rd_word;

    always_comb begin
        rd_word = DATA_RESET;
        if (ira_in_range(bridge_address_reg)) begin
            rd_word = mem[bridge_address_reg[3:0]];
        end
    end

    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[bridge_address_reg[3:0]] <= bridge_data_reg;
        end
    end

    // ------------------------------------------------------------
    // host request bridge
    // ------------------------------------------------------------
    ira_req_t req_reg;
    ira_req_t req_next;
    logic dw_reg;
    logic dw_next;
    logic [15:0] data_next;
    logic [7:0] addr_next;
    logic pend_next;
    logic irq_next;
    logic done;

    always_comb begin
        req_next = req_reg;
        dw_next = dw_reg;
        data_next = bridge_data_reg;
        addr_next = bridge_address_reg;
        mem_we = 1'b0;
        done = 1'b0;
        if (tick_reg) begin
            case (req_reg)
                IRA_WR: begin
                    mem_we = ira_in_range(bridge_address_reg);
                    req_next = IRA_IDLE;
                    done = 1'b1;
                end
                IRA_RD: begin
                    data_next = rd_word;
                    req_next = IRA_IDLE;
                    done = 1'b1;
                end
                IRA_IDLE: begin
                    req_next = IRA_IDLE;
                end
                default: begin
                    req_next = IRA_IDLE;
                end
            endcase
        end
        // a host write in the tick cycle overrides the read-back
        if (data_wr) begin
            data_next = wdata;
            dw_next = 1'b1;
        end
        if (addr_wr) begin
            addr_next = waddr;
            req_next = dw_next ? IRA_WR : IRA_RD;
            dw_next = 1'b0;
        end
        pend_next = req_next != IRA_IDLE;
        irq_next = transfer_complete_irq;
        if (irq_clear) begin
            irq_next = 1'b0;
        end
        // set wins over a clear in the same cycle
        if (done && irq_enable) begin
            irq_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            req_reg <= IRA_IDLE;
            dw_reg <= 1'b0;
            bridge_data_reg <= DATA_RESET;
            bridge_address_reg <= ADDR_RESET;
            bridge_pending_flag <= 1'b0;
            transfer_complete_irq <= 1'b0;
        end else begin
            req_reg <= req_next;
            dw_reg <= dw_next;
            bridge_data_reg <= data_next;
            bridge_address_reg <= addr_next;
            bridge_pending_flag <= pend_next;
            transfer_complete_irq <= irq_next;
        end
    end

    // ------------------------------------------------------------
    // threshold compare
    // ------------------------------------------------------------
    // ratio inputs arrive in the same scale as the threshold words
    ira_result_t res_next;

    always_comb begin
        res_next = result;
        if (eval_valid) begin
            res_next.valid = !ira_gt(mem[ADDR_DTMF_MIN_POWER[3:0]],
                eval.total_power);
            for (int i = 0; i < 4; i++) begin
                res_next.low_detect[i] = ira_gt(eval.low_ratio[i], mem[i]);
                res_next.high_detect[i] = ira_gt(eval.high_ratio[i],
                    mem[ADDR_HIGH_GROUP_PASS[3:0]]);
            end
            // twist passes while the ratio stays within its limit
            res_next.fwd_twist_ok = !ira_gt(eval.fwd_ratio,
                mem[ADDR_FORWARD_TWIST[3:0]]);
            res_next.rev_twist_ok = !ira_gt(eval.rev_ratio,
                mem[ADDR_REVERSE_TWIST[3:0]]);
            res_next.low_peak_ok = ira_gt(eval.low_peak_ratio,
                mem[ADDR_LOW_PEAK_RATIO[3:0]]);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            result <= RESULT_RESET;
        end else begin
            result <= res_next;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_service;
        tick_reg && req_reg != IRA_IDLE;
    endsequence

    property p_tick_gap;
        @(posedge clk) disable iff (!resetn)
        tick_reg |=> (!tick_reg) [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("update ticks too close");

    property p_tick_count;
        @(posedge clk) disable iff (!resetn)
        tick_reg |-> $past(cnt_reg) == TICK_LAST;
    endproperty
    a_tick_count: assert property (p_tick_count)
        else $error("update tick not at divider end");

    property p_write_req;
        @(posedge clk) disable iff (!resetn)
        addr_wr && (dw_reg || data_wr) |=> req_reg == IRA_WR && bridge_pending_flag;
    endproperty
    a_write_req: assert property (p_write_req)
        else $error("write request not recognised");

    property p_read_req;
        @(posedge clk) disable iff (!resetn)
        addr_wr && !dw_reg && !data_wr |=> req_reg == IRA_RD && bridge_pending_flag;
    endproperty
    a_read_req: assert property (p_read_req)
        else $error("read request not recognised");

    property p_pend_hold;
        @(posedge clk) disable iff (!resetn)
        req_reg != IRA_IDLE && !tick_reg |=> bridge_pending_flag;
    endproperty
    a_pend_hold: assert property (p_pend_hold)
        else $error("pending flag dropped before service");

    property p_pend_clear;
        @(posedge clk) disable iff (!resetn)
        s_service ##0 !addr_wr
        |=> !bridge_pending_flag ##1 (!bridge_pending_flag || $past(addr_wr));
    endproperty
    a_pend_clear: assert property (p_pend_clear)
        else $error("pending flag not cleared by service");

    property p_write_done;
        @(posedge clk) disable iff (!resetn)
        s_service ##0 req_reg == IRA_WR && bridge_address_reg == ADDR_DTMF_MIN_POWER
        |=> mem[ADDR_DTMF_MIN_POWER[3:0]] == $past(bridge_data_reg);
    endproperty
    a_write_done: assert property (p_write_done)
        else $error("indirect write not stored");

    property p_read_done;
        @(posedge clk) disable iff (!resetn)
        s_service ##0 req_reg == IRA_RD && !data_wr |=> bridge_data_reg == $past(rd_word);
    endproperty
    a_read_done: assert property (p_read_done)
        else $error("indirect read not returned");

    property p_irq;
        @(posedge clk) disable iff (!resetn)
        s_service ##0 irq_enable |=> transfer_complete_irq [*2] or irq_clear;
    endproperty
    a_irq: assert property (p_irq)
        else $error("completion interrupt missing");

    property p_min_power;
        @(posedge clk) disable iff (!resetn)
        eval_valid && ira_gt(mem[ADDR_DTMF_MIN_POWER[3:0]], eval.total_power)
        |=> !result.valid;
    endproperty
    a_min_power: assert property (p_min_power)
        else $error("low power evaluation kept");

    property p_unity_pass;
        @(posedge clk) disable iff (!resetn)
        eval_valid && eval.low_ratio[3] == PASS_UNITY && mem[3] == PASS_UNITY
        |=> !result.low_detect[3];
    endproperty
    a_unity_pass: assert property (p_unity_pass)
        else $error("equal ratio must not detect");

    property p_unity_twist;
        @(posedge clk) disable iff (!resetn)
        eval_valid && eval.fwd_ratio == TWIST_UNITY
        && mem[ADDR_FORWARD_TWIST[3:0]] == TWIST_UNITY |=> result.fwd_twist_ok;
    endproperty
    a_unity_twist: assert property (p_unity_twist)
        else $error("twist at limit rejected");

endmodule
